// File: src/rps_rx_protection_switch.v
// Purpose: receive protection selection and per-channel powerdown control
// Assumes: parallel bytes and overhead bits arrive on clk_sys after the alignment fifo
// Notes: select inputs from the fabric are treated as foreign and synchronised
// channel enables reset low, so every channel starts powered down
//
// What this block does
// R01: disabled channel powers down; per-channel software enable
// R02: drive parallel and overhead output enables
// R03: powerdown also reaches serial macro channel
// R04: all eight channels powered down after reset
// R05: receive-only switching over main/protect channel pairs
// R06: parallel selection after alignment fifo only
// R07: parallel selection works with pointer stage bypassed
// R08: pairs 0/1,2/3,4/5,6/7; first output switches
// R09: pair select 1 main, 0 protect
// R10: interface select moves parallel data only
// R11: software select moves parallel and overhead
// R12: per-channel work/protect buffer ahead of recovery
// R13: buffer select 0 work, 1 protect
// R14: no status for unselected buffers
// R15: software buffer control: enable bit, per-channel bits
// R16: software unlocks with key before protected writes
// R17: software enable overrides interface select inputs
`timescale 1ns/1ps
`include "rps_consts.vh"

module rps_rx_protection_switch #(
  parameter N_CH = 8,
  parameter BYTE_W = 8
) (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // register port
  input wire [`RPS_ADDR_W-1:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_r,
  output reg reg_rdata_valid_r,
  // configuration from the datapath
  input wire alignment_fifo_in_use,
  input wire pointer_stage_bypassed,
  // pair select inputs from fabric
  input wire pair_select_a_first,
  input wire pair_select_a_second,
  input wire pair_select_b_first,
  input wire pair_select_b_second,
  // buffer select inputs from fabric
  input wire buffer_select_ch0,
  input wire buffer_select_ch1,
  input wire buffer_select_ch2,
  input wire buffer_select_ch3,
  input wire buffer_select_ch4,
  input wire buffer_select_ch5,
  input wire buffer_select_ch6,
  input wire buffer_select_ch7,
  // per-channel receive data after the alignment fifo
  input wire [N_CH*BYTE_W-1:0] aligned_rx_byte_in,
  input wire [N_CH-1:0] serial_overhead_in,
  // data towards fabric
  output reg [N_CH*BYTE_W-1:0] parallel_rx_byte_out_r,
  output reg [N_CH-1:0] serial_overhead_out_r,
  output reg [N_CH-1:0] parallel_out_enable_r,
  output reg [N_CH-1:0] serial_overhead_out_enable_r,
  // towards the serial macro and buffer mux
  output reg [N_CH-1:0] high_speed_serial_macro_powerdown_r,
  output reg [N_CH-1:0] protect_buffer_select_r
);

  localparam N_PAIR = N_CH / 2;

  // registers
  reg [7:0] scratch_r;
  reg [7:0] lock_msb_r;
  reg [7:0] lock_lsb_r;
  reg [7:0] lvds_ctrl_r;
  reg [7:0] par_ctrl_r;
  reg [7:0] lvds_sel_r;
  reg [7:0] ch_en_r;
  reg write_err_r;
  reg [7:0] scratch_nxt;
  reg [7:0] lock_msb_nxt;
  reg [7:0] lock_lsb_nxt;
  reg [7:0] lvds_ctrl_nxt;
  reg [7:0] par_ctrl_nxt;
  reg [7:0] lvds_sel_nxt;
  reg [7:0] ch_en_nxt;
  reg write_err_nxt;
  reg [7:0] rdata_nxt;

  // synchronisers for fabric select inputs
  reg [N_PAIR+N_CH-1:0] sel_s1_r;
  reg [N_PAIR+N_CH-1:0] sel_s2_r;
  reg [N_PAIR+N_CH-1:0] sel_s3_r;
  reg [N_PAIR+N_CH-1:0] sel_val_r;
  wire [N_PAIR+N_CH-1:0] sel_val_nxt;
  wire [N_PAIR+N_CH-1:0] sel_raw;

  wire unlocked;
  wire in_locked_range;
  wire wr_ok;
  wire wr_denied;
  wire par_sw;
  wire lvds_sw;
  wire par_active;
  wire [N_PAIR-1:0] pair_main;
  wire [N_CH-1:0] buf_protect;
  wire [N_CH-1:0] ch_on;

  // pair selects in the low bits, buffer selects above them
  assign sel_raw[0] = pair_select_a_first;
  assign sel_raw[1] = pair_select_a_second;
  assign sel_raw[2] = pair_select_b_first;
  assign sel_raw[3] = pair_select_b_second;
  assign sel_raw[N_PAIR+0] = buffer_select_ch0;
  assign sel_raw[N_PAIR+1] = buffer_select_ch1;
  assign sel_raw[N_PAIR+2] = buffer_select_ch2;
  assign sel_raw[N_PAIR+3] = buffer_select_ch3;
  assign sel_raw[N_PAIR+4] = buffer_select_ch4;
  assign sel_raw[N_PAIR+5] = buffer_select_ch5;
  assign sel_raw[N_PAIR+6] = buffer_select_ch6;
  assign sel_raw[N_PAIR+7] = buffer_select_ch7;

  // three stages plus the agree rule cost four edges of select latency
  // a bit changes only once stages two and three agree
  assign sel_val_nxt = (sel_s2_r & sel_s3_r) | (sel_val_r & (sel_s2_r ^ sel_s3_r));

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel_s1_r <= {(N_PAIR+N_CH){1'b0}};
      sel_s2_r <= {(N_PAIR+N_CH){1'b0}};
      sel_s3_r <= {(N_PAIR+N_CH){1'b0}};
      sel_val_r <= {(N_PAIR+N_CH){1'b0}};
    end else begin
      sel_s1_r <= sel_raw;
      sel_s2_r <= sel_s1_r;
      sel_s3_r <= sel_s2_r;
      sel_val_r <= sel_val_nxt;
    end
  end

  // write protection
  // both key bytes must match; a half-written key keeps the core locked
  // scratch and lock bytes sit below the locked window, so unlock is always possible
  assign unlocked = (lock_msb_r == `RPS_KEY_MSB) && (lock_lsb_r == `RPS_KEY_LSB); // see R16
  assign in_locked_range = (reg_addr >= `RPS_ADDR_LOCKED_LO) && (reg_addr <= `RPS_ADDR_LOCKED_HI);
  assign wr_ok = reg_wr && (!in_locked_range || unlocked); // see R16
  assign wr_denied = reg_wr && in_locked_range && !unlocked;

  // software register next values; only accepted writes land
  always @* begin
    scratch_nxt = scratch_r;
    lock_msb_nxt = lock_msb_r;
    lock_lsb_nxt = lock_lsb_r;
    lvds_ctrl_nxt = lvds_ctrl_r;
    par_ctrl_nxt = par_ctrl_r;
    lvds_sel_nxt = lvds_sel_r;
    ch_en_nxt = ch_en_r;
    if (wr_ok) begin
      case (reg_addr)
        `RPS_ADDR_SCRATCH: scratch_nxt = reg_wdata;
        `RPS_ADDR_LOCK_MSB: lock_msb_nxt = reg_wdata;
        `RPS_ADDR_LOCK_LSB: lock_lsb_nxt = reg_wdata;
        `RPS_ADDR_LVDS_CTRL: lvds_ctrl_nxt = reg_wdata; // see R15
        `RPS_ADDR_PAR_CTRL: par_ctrl_nxt = reg_wdata; // see R11
        `RPS_ADDR_LVDS_SEL: lvds_sel_nxt = reg_wdata; // see R15
        `RPS_ADDR_CH_EN: ch_en_nxt = reg_wdata; // see R01
        default: ;
      endcase
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scratch_r <= `RPS_RST_BYTE;
      lock_msb_r <= `RPS_RST_BYTE;
      lock_lsb_r <= `RPS_RST_BYTE;
      lvds_ctrl_r <= `RPS_RST_BYTE;
      par_ctrl_r <= `RPS_RST_BYTE;
      lvds_sel_r <= `RPS_RST_BYTE;
      ch_en_r <= `RPS_RST_CH_EN; // see R04
    end else begin
      scratch_r <= scratch_nxt;
      lock_msb_r <= lock_msb_nxt;
      lock_lsb_r <= lock_lsb_nxt;
      lvds_ctrl_r <= lvds_ctrl_nxt;
      par_ctrl_r <= par_ctrl_nxt;
      lvds_sel_r <= lvds_sel_nxt;
      ch_en_r <= ch_en_nxt;
    end
  end

  // denied-write flag: set wins over clear-on-read
  always @* begin
    write_err_nxt = write_err_r;
    if (reg_rd && reg_addr == `RPS_ADDR_STATUS) begin
      write_err_nxt = 1'b0;
    end
    if (wr_denied) begin
      write_err_nxt = 1'b1; // see R16
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      write_err_r <= 1'b0;
    end else begin
      write_err_r <= write_err_nxt;
    end
  end

  // read port, one cycle latency; unmapped addresses read zero
  // status bit 1 mirrors the pointer stage bypass level for software
  always @* begin
    rdata_nxt = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `RPS_ADDR_SCRATCH: rdata_nxt = scratch_r;
        `RPS_ADDR_LOCK_MSB: rdata_nxt = lock_msb_r;
        `RPS_ADDR_LOCK_LSB: rdata_nxt = lock_lsb_r;
        `RPS_ADDR_LVDS_CTRL: rdata_nxt = lvds_ctrl_r;
        `RPS_ADDR_PAR_CTRL: rdata_nxt = par_ctrl_r;
        `RPS_ADDR_LVDS_SEL: rdata_nxt = lvds_sel_r;
        `RPS_ADDR_CH_EN: rdata_nxt = ch_en_r;
        `RPS_ADDR_STATUS: rdata_nxt = {6'h00, pointer_stage_bypassed, write_err_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_r <= 8'h00;
      reg_rdata_valid_r <= 1'b0;
    end else begin
      reg_rdata_r <= rdata_nxt;
      reg_rdata_valid_r <= reg_rd;
    end
  end

  // selection sources
  assign par_sw = par_ctrl_r[`RPS_PAR_SW_EN_BIT];
  assign lvds_sw = lvds_ctrl_r[`RPS_LVDS_SW_EN_BIT];
  assign pair_main = par_sw ? par_ctrl_r[N_PAIR-1:0] : sel_val_r[N_PAIR-1:0]; // see R17 R09
  assign buf_protect = lvds_sw ? lvds_sel_r[N_CH-1:0] : sel_val_r[N_PAIR+N_CH-1:N_PAIR]; // see R17 R13
  // switching needs the fifo-aligned bytes; pointer stage state is irrelevant here
  assign par_active = alignment_fifo_in_use; // see R06 R07
  assign ch_on = ch_en_r[N_CH-1:0];

  // per-pair receive selection; transmit side is untouched by design
  genvar p;
  generate
    for (p = 0; p < N_PAIR; p = p + 1) begin : g_pair
      wire take_protect;
      wire [BYTE_W-1:0] main_byte;
      wire [BYTE_W-1:0] prot_byte;
      wire [BYTE_W-1:0] first_byte;
      wire first_toh;
      wire [BYTE_W-1:0] first_byte_nxt;
      wire [BYTE_W-1:0] second_byte_nxt;
      wire first_toh_nxt;
      wire second_toh_nxt;
      assign main_byte = aligned_rx_byte_in[(2*p)*BYTE_W +: BYTE_W];
      assign prot_byte = aligned_rx_byte_in[(2*p+1)*BYTE_W +: BYTE_W];
      assign take_protect = par_active && !pair_main[p]; // see R05 R09
      assign first_byte = take_protect ? prot_byte : main_byte; // see R08
      // overhead follows only under software control
      assign first_toh = (take_protect && par_sw) ? serial_overhead_in[2*p+1] : serial_overhead_in[2*p]; // see R10 R11
      // a disabled channel shows zero, never stale data; second channel keeps its own
      assign first_byte_nxt = ch_on[2*p] ? first_byte : {BYTE_W{1'b0}}; // see R01
      assign second_byte_nxt = ch_on[2*p+1] ? prot_byte : {BYTE_W{1'b0}}; // see R01
      assign first_toh_nxt = ch_on[2*p] & first_toh;
      assign second_toh_nxt = ch_on[2*p+1] & serial_overhead_in[2*p+1];

      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          parallel_rx_byte_out_r[(2*p)*BYTE_W +: BYTE_W] <= {BYTE_W{1'b0}};
          parallel_rx_byte_out_r[(2*p+1)*BYTE_W +: BYTE_W] <= {BYTE_W{1'b0}};
          serial_overhead_out_r[2*p] <= 1'b0;
          serial_overhead_out_r[2*p+1] <= 1'b0;
        end else begin
          parallel_rx_byte_out_r[(2*p)*BYTE_W +: BYTE_W] <= first_byte_nxt;
          parallel_rx_byte_out_r[(2*p+1)*BYTE_W +: BYTE_W] <= second_byte_nxt;
          serial_overhead_out_r[2*p] <= first_toh_nxt;
          serial_overhead_out_r[2*p+1] <= second_toh_nxt;
        end
      end
    end
  endgenerate

  // powerdown, output enables and buffer choice, one slice per channel
  genvar c;
  generate
    for (c = 0; c < N_CH; c = c + 1) begin : g_chan
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          parallel_out_enable_r[c] <= 1'b0;
          serial_overhead_out_enable_r[c] <= 1'b0;
          high_speed_serial_macro_powerdown_r[c] <= 1'b1; // see R04
          protect_buffer_select_r[c] <= 1'b0;
        end else begin
          parallel_out_enable_r[c] <= ch_on[c]; // see R02
          serial_overhead_out_enable_r[c] <= ch_on[c]; // see R02
          high_speed_serial_macro_powerdown_r[c] <= !ch_on[c]; // see R01 R03
          // drives the buffer mux ahead of recovery; no per-buffer status exists
          protect_buffer_select_r[c] <= buf_protect[c]; // see R12 R14
        end
      end
    end
  endgenerate

endmodule // rps_rx_protection_switch

// File: src/rps_consts.vh
// Purpose: constants for the receive protection switch and channel powerdown
// Assumes: byte-wide register port at absolute core addresses
// Notes: definitions only
`ifndef RPS_CONSTS_VH
`define RPS_CONSTS_VH

`define RPS_ADDR_W 18
`define RPS_ADDR_SCRATCH 18'h30003
`define RPS_ADDR_LOCK_MSB 18'h30004
`define RPS_ADDR_LOCK_LSB 18'h30005
`define RPS_ADDR_LOCKED_LO 18'h30006
`define RPS_ADDR_LOCKED_HI 18'h300ff
`define RPS_ADDR_LVDS_CTRL 18'h30008
`define RPS_ADDR_PAR_CTRL 18'h30009
`define RPS_ADDR_LVDS_SEL 18'h3000a
`define RPS_ADDR_CH_EN 18'h3000b
`define RPS_ADDR_STATUS 18'h3000c

`define RPS_KEY_MSB 8'h05
`define RPS_KEY_LSB 8'h80

`define RPS_LVDS_SW_EN_BIT 0
`define RPS_PAR_SW_EN_BIT 4
`define RPS_STAT_WERR_BIT 0

`define RPS_RST_BYTE 8'h00
`define RPS_RST_CH_EN 8'h00

`endif

// File: test/rps_fabric_model.sv
// Purpose: fabric side model driving the select levels
// Assumes: levels launched on rising clk_sys
// Notes: holds each command until the next
`timescale 1ns/1ps
module rps_fabric_model (
  // clock
  input wire clk_sys,
  // commands from bench
  input wire [3:0] pair_cmd,
  input wire [7:0] buf_cmd,
  // levels to the core
  output reg [3:0] pair_sel_r,
  output reg [7:0] buf_sel_r
);
  initial pair_sel_r = 4'h0;
  initial buf_sel_r = 8'h00;
  always @(posedge clk_sys) begin
    pair_sel_r <= pair_cmd;
    buf_sel_r <= buf_cmd;
  end
endmodule // rps_fabric_model

// File: test/rps_rx_protection_switch_chk.sv
// Purpose: port checks for the protection switch
// Assumes: bound to the top module ports
// Notes: enable outputs stand in for channel enable
`timescale 1ns/1ps
`include "rps_consts.vh"
module rps_rx_protection_switch_chk (
  input wire clk_sys,
  input wire rst_n,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata_r,
  input wire reg_rdata_valid_r,
  input wire [63:0] aligned_rx_byte_in,
  input wire [7:0] serial_overhead_in,
  input wire [63:0] parallel_rx_byte_out_r,
  input wire [7:0] serial_overhead_out_r,
  input wire [7:0] parallel_out_enable_r,
  input wire [7:0] serial_overhead_out_enable_r,
  input wire [7:0] high_speed_serial_macro_powerdown_r
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_rd_once;
    reg_rd ##1 !reg_rd;
  endsequence
  sequence s_valid_pulse;
    reg_rdata_valid_r ##1 !reg_rdata_valid_r;
  endsequence
  a_rd_answer_pulse: assert property (s_rd_once |-> s_valid_pulse) else $error("read answer not a pulse");
  a_rdata_idle_zero: assert property (!reg_rdata_valid_r |-> reg_rdata_r == 8'h00) else $error("rdata not zero");
  a_wr_no_answer: assert property (reg_wr && !reg_rd |=> !reg_rdata_valid_r) else $error("write gave answer");
  a_pd_follows_en: assert property (high_speed_serial_macro_powerdown_r == ~parallel_out_enable_r)
    else $error("powerdown not inverse of enable");
  a_oe_pair_match: assert property (serial_overhead_out_enable_r == parallel_out_enable_r)
    else $error("enables differ");
  a_off_oh_zero: assert property ((serial_overhead_out_r & ~parallel_out_enable_r) == 8'h00)
    else $error("disabled overhead not zero");
  a_second_own_byte: assert property (parallel_out_enable_r[1] |->
    parallel_rx_byte_out_r[15:8] == $past(aligned_rx_byte_in[15:8])) else $error("second channel byte moved");
  a_second_own_oh: assert property (parallel_out_enable_r[3] |->
    serial_overhead_out_r[3] == $past(serial_overhead_in[3])) else $error("second channel overhead moved");
  a_en_needs_write: assert property ($changed(parallel_out_enable_r) |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("enable changed without write");
endmodule // rps_rx_protection_switch_chk
bind rps_rx_protection_switch rps_rx_protection_switch_chk i_chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .reg_rdata_valid_r(reg_rdata_valid_r),
  .aligned_rx_byte_in(aligned_rx_byte_in), .serial_overhead_in(serial_overhead_in),
  .parallel_rx_byte_out_r(parallel_rx_byte_out_r), .serial_overhead_out_r(serial_overhead_out_r),
  .parallel_out_enable_r(parallel_out_enable_r), .serial_overhead_out_enable_r(serial_overhead_out_enable_r),
  .high_speed_serial_macro_powerdown_r(high_speed_serial_macro_powerdown_r));

// File: test/tb_top.sv
// Purpose: self-checking bench for the protection switch
// Assumes: select levels settle within eight edges
// Notes: overhead switching checked with fifo in use only
`timescale 1ns/1ps
`include "rps_consts.vh"
module tb_top;
  reg clk_sys = 1'b0;
  reg rst_n = 1'b0;
  reg [17:0] reg_addr = 18'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg fifo_use = 1'b1;
  reg ptr_byp = 1'b0;
  reg [3:0] pair_cmd = 4'h0;
  reg [3:0] s;
  reg [7:0] reg_wdata = 8'h00, buf_cmd = 8'h00, oh_in = 8'h00, rd_v, en, b;
  reg [63:0] d_in = 64'h0;
  wire [3:0] ps;
  wire [7:0] bs, rdata, oh_out, oe_p, oe_o, pd, bsel;
  wire rvalid;
  wire [63:0] d_out;
  integer error_cnt = 0, cmp_count = 0, cyc = 0, i;
  initial forever #2 clk_sys = ~clk_sys;
  rps_fabric_model i_rps_fabric_model (.clk_sys(clk_sys), .pair_cmd(pair_cmd), .buf_cmd(buf_cmd),
    .pair_sel_r(ps), .buf_sel_r(bs));
  rps_rx_protection_switch i_rps_rx_protection_switch (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_r(rdata), .reg_rdata_valid_r(rvalid),
    .alignment_fifo_in_use(fifo_use), .pointer_stage_bypassed(ptr_byp), .pair_select_a_first(ps[0]),
    .pair_select_a_second(ps[1]), .pair_select_b_first(ps[2]), .pair_select_b_second(ps[3]),
    .buffer_select_ch0(bs[0]), .buffer_select_ch1(bs[1]), .buffer_select_ch2(bs[2]), .buffer_select_ch3(bs[3]),
    .buffer_select_ch4(bs[4]), .buffer_select_ch5(bs[5]), .buffer_select_ch6(bs[6]), .buffer_select_ch7(bs[7]),
    .aligned_rx_byte_in(d_in), .serial_overhead_in(oh_in), .parallel_rx_byte_out_r(d_out),
    .serial_overhead_out_r(oh_out), .parallel_out_enable_r(oe_p), .serial_overhead_out_enable_r(oe_o),
    .high_speed_serial_macro_powerdown_r(pd), .protect_buffer_select_r(bsel));
  task close_out;
    begin
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input [71:0] seen, input [71:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [17:0] a, input [7:0] v);
    begin
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [17:0] a);
    begin
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 rd_v = rdata;
    end
  endtask
  // first channel of a pair takes its partner on protect
  function [71:0] exp_out(input [3:0] sel, input sw);
    integer c;
    reg [7:0] x;
    reg o;
    begin
      for (c = 0; c < 8; c = c + 1) begin
        x = d_in[8*c +: 8];
        o = oh_in[c];
        if (c % 2 == 0 && fifo_use && !sel[c/2]) begin
          x = d_in[8*c+8 +: 8];
          if (sw) o = oh_in[c+1];
        end
        exp_out[8*c +: 8] = en[c] ? x : 8'h00;
        exp_out[64+c] = en[c] & o;
      end
    end
  endfunction
  task run(input sw);
    begin
      @(posedge clk_sys);
      d_in <= {$urandom, $urandom};
      oh_in <= $urandom;
      ptr_byp <= $urandom;
      repeat (8) @(posedge clk_sys);
      #1 chk({oh_out, d_out}, exp_out(s, sw));
    end
  endtask
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 6000) begin
      error_cnt = error_cnt + 1;
      close_out;
    end
  end
  initial begin
    i = $urandom(77);
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1 chk({oe_p, pd}, 16'h00ff);
    wr(`RPS_ADDR_CH_EN, 8'hff);
    rd(`RPS_ADDR_CH_EN);
    chk(rd_v, `RPS_RST_CH_EN);
    rd(`RPS_ADDR_STATUS);
    chk(rd_v, 8'h01);
    rd(18'h30020);
    chk(rd_v, 8'h00);
    wr(`RPS_ADDR_LOCK_MSB, `RPS_KEY_MSB);
    wr(`RPS_ADDR_LOCK_LSB, `RPS_KEY_LSB);
    $display("test lock done");
    for (i = 0; i < 6; i = i + 1) begin
      en = (i == 0) ? 8'hff : $urandom;
      wr(`RPS_ADDR_CH_EN, en);
      s = $urandom;
      pair_cmd <= s;
      fifo_use <= (i != 5);
      run(1'b0);
      chk(pd, en ^ 8'hff);
      chk({oe_p, oe_o}, {en, en});
      rd(`RPS_ADDR_STATUS);
      chk(rd_v, {6'h00, ptr_byp, 1'b0});
      fifo_use <= 1'b1;
      s = $urandom;
      wr(`RPS_ADDR_PAR_CTRL, {4'h1, s});
      pair_cmd <= ~s;
      run(1'b1);
      wr(`RPS_ADDR_PAR_CTRL, 8'h00);
      b = $urandom;
      buf_cmd <= b;
      repeat (8) @(posedge clk_sys);
      #1 chk(bsel, b);
      wr(`RPS_ADDR_LVDS_SEL, b ^ 8'hff);
      wr(`RPS_ADDR_LVDS_CTRL, 8'h01);
      rd(`RPS_ADDR_LVDS_CTRL);
      chk(rd_v, 8'h01);
      repeat (3) @(posedge clk_sys);
      #1 chk(bsel, b ^ 8'hff);
      wr(`RPS_ADDR_LVDS_CTRL, 8'h00);
      $display("test pass %0d done", i);
    end
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1 chk({oe_p, pd}, 16'h00ff);
    wr(`RPS_ADDR_CH_EN, 8'hff);
    repeat (2) @(posedge clk_sys);
    #1 chk(pd, 8'hff);
    $display("test reset done");
    close_out;
  end
endmodule // tb_top
